/* File: hdl/smm_monitor.sv */
/*
  Serial monitor mode command interpreter with forced entry, security
  check, echo and memory access.
  Assumes a single-cycle memory port and a core that takes vector and
  resume requests from the outputs below.
*/
`include "smm_regs.svh"

module smm_monitor #(
  parameter int CLK_HZ = `SMM_CLK_HZ,
  parameter int PLL_BAUD = `SMM_BAUD_PLL,
  parameter int REF_DIV = `SMM_REF_DIV,
  parameter int REF_CLK_DIV = 2
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  input wire logic powerOnReset,
  // Mode pins.
  input wire logic externalInterruptPinLow,
  input wire logic elevatedTestVoltage,
  // Core vector fetch and control.
  input wire logic resetVectorFetch,
  input wire logic [15:0] resetVectorValue,
  input wire logic romExecAttempt,
  output logic internalReset,
  output logic illegalAddressReset,
  output logic monitorMode,
  output logic watchdogEnable,
  output logic [15:0] resetVectorAddr,
  output logic [15:0] swiVectorAddr,
  output logic returnFromInterrupt,
  input wire logic [7:0] stackPointer,
  // Memory port.
  output logic memRead,
  output logic memWrite,
  output logic [15:0] memAddr,
  output logic [7:0] memWdata,
  input wire logic [7:0] memRdata,
  input wire logic memIsRom,
  // Serial pins.
  input wire logic monitorReceivePin,
  output logic monitorTransmitPin
);

  localparam int TICK_W = 20;
  localparam int PLL_TICKS = CLK_HZ / PLL_BAUD;
  localparam int REF_TICKS = REF_DIV * REF_CLK_DIV;

  // ----------------------------------------------------------------
  // Mode and forced entry.
  // ----------------------------------------------------------------
  logic forced;
  logic voltageEntry;
  logic vectorErased;
  logic bypassPll;
  logic secured;
  logic secFlag;

  assign vectorErased = (resetVectorValue == {2{`SMM_ERASED_BYTE}});

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      internalReset <= 1'b0;
    end else begin
      internalReset <= resetVectorFetch && vectorErased && !forced &&
        !powerOnReset;
    end
  end

  // Forced mode survives every reset except power-on.
  always_ff @(posedge clk) begin
    if (powerOnReset) begin
      forced <= 1'b0;
      bypassPll <= 1'b0;
    end else if (resetVectorFetch && vectorErased && !forced) begin
      forced <= 1'b1;
      bypassPll <= externalInterruptPinLow;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      voltageEntry <= 1'b0;
    end else begin
      voltageEntry <= elevatedTestVoltage;
    end
  end

  assign monitorMode = forced || voltageEntry;
  // Off while forced or while the high voltage stays.
  assign watchdogEnable = !forced && !elevatedTestVoltage;
  assign resetVectorAddr = monitorMode ? `SMM_VEC_RST_MON
                                       : `SMM_VEC_RST_USER;
  assign swiVectorAddr = monitorMode ? `SMM_VEC_SWI_MON
                                     : `SMM_VEC_SWI_USER;
  assign illegalAddressReset = monitorMode && !secured && romExecAttempt;

  // ----------------------------------------------------------------
  // Serial line.
  // ----------------------------------------------------------------
  smm_link_if link ();
  logic [TICK_W-1:0] bitTicks;

  assign bitTicks = bypassPll ? TICK_W'(REF_TICKS) : TICK_W'(PLL_TICKS);

  smm_serial_line #(
    .TICK_W(TICK_W)
  ) u_line (
    .clk(clk),
    .resetn(resetn),
    .bitTicks(bitTicks),
    .rxPin(monitorReceivePin),
    .txPin(monitorTransmitPin),
    .link(link)
  );

  // ----------------------------------------------------------------
  // Command interpreter.
  // ----------------------------------------------------------------
  smm_pkg::smm_cmd_e state;
  logic [7:0] opcode;
  logic [15:0] addr;
  logic [3:0] secCount;
  logic secMatch;
  logic [1:0] sendLeft;
  logic [7:0] sendByte;
  logic echoPend;
  logic [7:0] echoByte;
  logic brkPend;
  logic [TICK_W+1:0] brkWait;

  assign link.txByte = echoPend ? echoByte : sendByte;
  // Echo goes first so returned data follows it.
  assign link.txSend = !link.txBusy && !link.txBreak &&
    (echoPend || (state == smm_pkg::SMM_C_SEND && sendLeft != 2'h0));
  assign link.txBreak = !link.txBusy && brkPend && brkWait == '0;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      echoPend <= 1'b0;
      echoByte <= 8'h00;
    end else if (link.rxValid) begin
      echoPend <= 1'b1;
      echoByte <= link.rxByte;
    end else if (link.txSend && echoPend) begin
      echoPend <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      brkPend <= 1'b0;
      brkWait <= '0;
    end else if (link.rxBreak) begin
      brkPend <= 1'b1;
      brkWait <= (TICK_W+2)'(bitTicks) * (TICK_W+2)'(`SMM_BREAK_GAP_BITS);
    end else if (state == smm_pkg::SMM_C_BRK && !brkPend) begin
      brkPend <= 1'b1;
      brkWait <= '0;
    end else if (link.txBreak) begin
      brkPend <= 1'b0;
    end else if (brkWait != '0) begin
      brkWait <= brkWait - (TICK_W+2)'(1);
    end
  end

  // Security state is kept through non power-on resets.
  always_ff @(posedge clk) begin
    if (powerOnReset) begin
      secured <= 1'b0;
      secFlag <= 1'b0;
    end else if (state == smm_pkg::SMM_C_BRK && secMatch) begin
      secured <= 1'b1;
      secFlag <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= smm_pkg::SMM_C_SEC;
      opcode <= 8'h00;
      addr <= 16'h0000;
      secCount <= 4'h0;
      secMatch <= 1'b1;
      sendLeft <= 2'h0;
      sendByte <= 8'h00;
      returnFromInterrupt <= 1'b0;
    end else begin
      returnFromInterrupt <= 1'b0;
      case (state)
        smm_pkg::SMM_C_SEC: begin
          if (secured && monitorMode) begin
            state <= smm_pkg::SMM_C_BRK;
          end else if (!monitorMode) begin
            secCount <= 4'h0;
          end else if (link.rxValid) begin
            if (link.rxByte != memRdata) begin
              secMatch <= 1'b0;
            end
            if (secCount == `SMM_SEC_COUNT - 4'h1) begin
              state <= smm_pkg::SMM_C_BRK;
            end
            secCount <= secCount + 4'h1;
          end
        end
        smm_pkg::SMM_C_BRK: begin
          state <= smm_pkg::SMM_C_OP;
        end
        smm_pkg::SMM_C_OP: begin
          if (link.rxValid) begin
            opcode <= link.rxByte;
            case (link.rxByte)
              `SMM_OP_WRITE, `SMM_OP_READ: state <= smm_pkg::SMM_C_AHI;
              `SMM_OP_INDEXED_WRITE_CMD: state <= smm_pkg::SMM_C_DATA;
              `SMM_OP_INDEXED_READ_CMD: begin
                addr <= addr + 16'h0001;
                sendLeft <= 2'h2;
                state <= smm_pkg::SMM_C_MEM;
              end
              `SMM_OP_STACK_POINTER_READ_CMD: begin
                sendByte <= stackPointer;
                sendLeft <= 2'h1;
                state <= smm_pkg::SMM_C_SEND;
              end
              `SMM_OP_RUN: state <= smm_pkg::SMM_C_RUN;
              default: state <= smm_pkg::SMM_C_OP;
            endcase
          end
        end
        smm_pkg::SMM_C_AHI: begin
          if (link.rxValid) begin
            addr[15:8] <= link.rxByte;
            state <= smm_pkg::SMM_C_ALO;
          end
        end
        smm_pkg::SMM_C_ALO: begin
          if (link.rxValid) begin
            addr[7:0] <= link.rxByte;
            if (opcode == `SMM_OP_READ) begin
              sendLeft <= 2'h1;
              state <= smm_pkg::SMM_C_MEM;
            end else begin
              state <= smm_pkg::SMM_C_DATA;
            end
          end
        end
        smm_pkg::SMM_C_DATA: begin
          if (link.rxValid) begin
            if (opcode == `SMM_OP_INDEXED_WRITE_CMD) begin
              addr <= addr + 16'h0001;
            end
            state <= smm_pkg::SMM_C_OP;
          end
        end
        smm_pkg::SMM_C_MEM: begin
          sendByte <= (memIsRom && !secured) ? `SMM_INVALID_BYTE
                                             : memRdata;
          state <= smm_pkg::SMM_C_SEND;
        end
        smm_pkg::SMM_C_SEND: begin
          if (link.txSend && !echoPend) begin
            if (sendLeft == 2'h1) begin
              sendLeft <= 2'h0;
              state <= smm_pkg::SMM_C_OP;
            end else begin
              sendLeft <= sendLeft - 2'h1;
              addr <= addr + 16'h0001;
              state <= smm_pkg::SMM_C_MEM;
            end
          end
        end
        smm_pkg::SMM_C_RUN: begin
          if (!echoPend && !link.txBusy) begin
            returnFromInterrupt <= 1'b1;
            state <= smm_pkg::SMM_C_OP;
          end
        end
        default: state <= smm_pkg::SMM_C_OP;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Memory port.
  // ----------------------------------------------------------------
  logic writeNow;

  assign writeNow = state == smm_pkg::SMM_C_DATA && link.rxValid;
  assign memWrite = writeNow || state == smm_pkg::SMM_C_BRK;
  assign memRead = state == smm_pkg::SMM_C_SEC ||
                   state == smm_pkg::SMM_C_MEM;

  always_comb begin
    memAddr = addr;
    memWdata = link.rxByte;
    if (state == smm_pkg::SMM_C_SEC) begin
      memAddr = `SMM_SEC_BASE + {12'h000, secCount};
    end else if (state == smm_pkg::SMM_C_BRK) begin
      memAddr = `SMM_SEC_FLAG_ADDR;
      memWdata = 8'h00;
      memWdata[`SMM_SEC_FLAG_BIT] = secMatch || secFlag;
    end else if (writeNow && opcode == `SMM_OP_INDEXED_WRITE_CMD) begin
      memAddr = addr + 16'h0001;
    end
  end

endmodule

/* File: hdl/smm_regs.svh */
/*
  Constants for the serial monitor block: command opcodes, vector and
  security addresses, baud divisors and timing counts.
  Assumes it is included by bare name from the design files.
*/
`ifndef SMM_REGS_SVH
`define SMM_REGS_SVH

`define SMM_OP_WRITE 8'h49
`define SMM_OP_READ 8'h4a
`define SMM_OP_INDEXED_READ_CMD 8'h1a
`define SMM_OP_INDEXED_WRITE_CMD 8'h19
`define SMM_OP_STACK_POINTER_READ_CMD 8'h0c
`define SMM_OP_RUN 8'h28

`define SMM_VEC_RST_USER 16'hfffe
`define SMM_VEC_RST_MON 16'hfefe
`define SMM_VEC_SWI_USER 16'hfffc
`define SMM_VEC_SWI_MON 16'hfefc
`define SMM_SEC_BASE 16'hfff6
`define SMM_SEC_LAST 16'hfffd
`define SMM_SEC_COUNT 4'h8
`define SMM_SEC_FLAG_ADDR 16'h0060
`define SMM_SEC_FLAG_BIT 6
`define SMM_ERASED_BYTE 8'hff
`define SMM_INVALID_BYTE 8'had

`define SMM_CLK_HZ 250000000
`define SMM_BAUD_PLL 9600
`define SMM_REF_DIV 1024
`define SMM_BREAK_BITS 4'h9
`define SMM_BREAK_GAP_BITS 4'h2
`define SMM_DATA_BITS 4'h8

`endif

/* File: hdl/smm_pkg.sv */
/*
  Types shared by the serial monitor modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package smm_pkg;
  typedef enum logic [2:0] {
    SMM_RX_IDLE,
    SMM_RX_DATA,
    SMM_RX_STOP
  } smm_rx_e;

  typedef enum logic [3:0] {
    SMM_C_SEC,
    SMM_C_BRK,
    SMM_C_OP,
    SMM_C_AHI,
    SMM_C_ALO,
    SMM_C_DATA,
    SMM_C_MEM,
    SMM_C_SEND,
    SMM_C_RUN
  } smm_cmd_e;
endpackage

/* File: hdl/smm_link_if.sv */
/*
  Byte link between the command interpreter and the serial line module.
  Assumes both ends share clk.
*/
interface smm_link_if;
  logic [7:0] rxByte;
  logic rxValid;
  logic rxBreak;
  logic [7:0] txByte;
  logic txSend;
  logic txBreak;
  logic txBusy;

  modport line (output rxByte, output rxValid, output rxBreak,
    input txByte, input txSend, input txBreak, output txBusy);
  modport core (input rxByte, input rxValid, input rxBreak,
    output txByte, output txSend, output txBreak, input txBusy);
endinterface

/* File: hdl/smm_serial_line.sv */
/*
  NRZ serial receiver and transmitter with break detection.
  Assumes the receive pin is synchronous to clk and bitTicks is stable.
*/
`include "smm_regs.svh"

module smm_serial_line #(
  parameter int TICK_W = 20
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Bit time in clocks.
  input wire logic [TICK_W-1:0] bitTicks,
  // Pins.
  input wire logic rxPin,
  output logic txPin,
  // Byte side.
  smm_link_if.line link
);

  // ----------------------------------------------------------------
  // Receiver.
  // ----------------------------------------------------------------
  smm_pkg::smm_rx_e rxState;
  logic [TICK_W-1:0] rxCnt;
  logic [3:0] rxBit;
  logic [7:0] rxShift;
  logic rxAllLow;
  logic [TICK_W-1:0] halfTicks;
  logic rxLast;

  assign halfTicks = bitTicks >> 1;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxState <= smm_pkg::SMM_RX_IDLE;
      rxCnt <= '0;
      rxBit <= 4'h0;
      rxShift <= 8'h00;
      rxAllLow <= 1'b0;
      rxLast <= 1'b1;
      link.rxByte <= 8'h00;
      link.rxValid <= 1'b0;
      link.rxBreak <= 1'b0;
    end else begin
      link.rxValid <= 1'b0;
      link.rxBreak <= 1'b0;
      rxLast <= rxPin;
      case (rxState)
        smm_pkg::SMM_RX_IDLE: begin
          rxCnt <= halfTicks;
          rxBit <= 4'h0;
          rxAllLow <= 1'b1;
          // Only a falling edge starts a frame, so the low tail of a
          // break is not taken for a new start bit.
          if (rxLast && !rxPin) begin
            rxState <= smm_pkg::SMM_RX_DATA;
          end
        end
        smm_pkg::SMM_RX_DATA: begin
          if (rxCnt == '0) begin
            rxCnt <= bitTicks - TICK_W'(1);
            if (rxBit != 4'h0) begin
              // LSB first.
              rxShift <= {rxPin, rxShift[7:1]};
              if (rxPin) begin
                rxAllLow <= 1'b0;
              end
            end
            if (rxBit == `SMM_DATA_BITS) begin
              rxState <= smm_pkg::SMM_RX_STOP;
            end
            rxBit <= rxBit + 4'h1;
          end else begin
            rxCnt <= rxCnt - TICK_W'(1);
          end
        end
        smm_pkg::SMM_RX_STOP: begin
          if (rxCnt == '0) begin
            // Start plus nine low bits is a break.
            if (!rxPin && rxAllLow) begin
              link.rxBreak <= 1'b1;
            end else if (rxPin) begin
              link.rxByte <= rxShift;
              link.rxValid <= 1'b1;
            end
            rxState <= smm_pkg::SMM_RX_IDLE;
          end else begin
            rxCnt <= rxCnt - TICK_W'(1);
          end
        end
        default: rxState <= smm_pkg::SMM_RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transmitter.
  // ----------------------------------------------------------------
  logic [9:0] txShift;
  logic [3:0] txLeft;
  logic [TICK_W-1:0] txCnt;

  assign link.txBusy = (txLeft != 4'h0);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txShift <= 10'h3ff;
      txLeft <= 4'h0;
      txCnt <= '0;
      txPin <= 1'b1;
    end else if (txLeft == 4'h0) begin
      txPin <= 1'b1;
      if (link.txSend || link.txBreak) begin
        // Break is ten zeros, else start, data, stop.
        txShift <= link.txBreak ? 10'h000 : {1'b1, link.txByte, 1'b0};
        // The eleventh step ends the tenth bit, so the stop bit is held for a whole bit time.
        txLeft <= 4'hb;
        txCnt <= '0;
      end
    end else if (txCnt == '0) begin
      txPin <= txShift[0];
      txShift <= {1'b1, txShift[9:1]};
      txCnt <= bitTicks - TICK_W'(1);
      txLeft <= txLeft - 4'h1;
    end else begin
      txCnt <= txCnt - TICK_W'(1);
    end
  end

endmodule

/* File: bench/smm_monitor_sva.sv */
/*
  Concurrent checks on the ports of the serial monitor top module.
  Assumes it is bound to smm_monitor and sees only its ports.
*/
module smm_monitor_sva (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Watched ports.
  input wire logic elevatedTestVoltage,
  input wire logic resetVectorFetch,
  input wire logic [15:0] resetVectorValue,
  input wire logic romExecAttempt,
  input wire logic internalReset,
  input wire logic illegalAddressReset,
  input wire logic monitorMode,
  input wire logic watchdogEnable,
  input wire logic [15:0] resetVectorAddr,
  input wire logic [15:0] swiVectorAddr,
  input wire logic returnFromInterrupt,
  input wire logic memWrite,
  input wire logic memRead,
  input wire logic monitorTransmitPin
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_erased_vec: assert property (
    resetVectorFetch && resetVectorValue == 16'hffff && !monitorMode
    |=> internalReset) else $error("erased vector gave no reset");
  a_reset_cause: assert property (
    $rose(internalReset) |-> $past(resetVectorFetch) &&
    $past(resetVectorValue) == 16'hffff) else $error("reset without cause");
  a_forced_entry: assert property (
    internalReset |-> ##[1:4] monitorMode) else $error("no forced entry");
  a_wdog_forced: assert property (
    internalReset |=> (!watchdogEnable) [*8])
    else $error("watchdog on in forced mode");
  a_wdog_hv: assert property (
    elevatedTestVoltage |-> !watchdogEnable)
    else $error("watchdog on under high voltage");
  a_mon_vectors: assert property (
    monitorMode |-> resetVectorAddr == 16'hfefe &&
    swiVectorAddr == 16'hfefc) else $error("monitor vectors wrong");
  a_user_vectors: assert property (
    !monitorMode |-> resetVectorAddr == 16'hfffe &&
    swiVectorAddr == 16'hfffc) else $error("user vectors wrong");
  a_tx_idle: assert property (
    $rose(resetn) |-> monitorTransmitPin) else $error("line not idle");
  a_start_bit: assert property (
    $fell(monitorTransmitPin) |=> (!monitorTransmitPin) [*8])
    else $error("start bit too short");
  a_illegal_src: assert property (
    illegalAddressReset |-> romExecAttempt && monitorMode)
    else $error("illegal reset without cause");
  a_wr_mon: assert property (
    memWrite |-> monitorMode) else $error("write outside monitor");
  a_rfi_pulse: assert property (
    returnFromInterrupt |=> !returnFromInterrupt)
    else $error("run pulse too long");
  a_mem_excl: assert property (
    memWrite |-> !memRead) else $error("read and write together");
endmodule

bind smm_monitor smm_monitor_sva u_sva (
  .clk(clk), .resetn(resetn), .elevatedTestVoltage(elevatedTestVoltage),
  .resetVectorFetch(resetVectorFetch), .resetVectorValue(resetVectorValue),
  .romExecAttempt(romExecAttempt), .internalReset(internalReset),
  .illegalAddressReset(illegalAddressReset), .monitorMode(monitorMode),
  .watchdogEnable(watchdogEnable), .resetVectorAddr(resetVectorAddr),
  .swiVectorAddr(swiVectorAddr), .returnFromInterrupt(returnFromInterrupt),
  .memWrite(memWrite), .memRead(memRead),
  .monitorTransmitPin(monitorTransmitPin)
);

/* File: bench/smm_host.sv */
/*
  Host computer model on the serial link: sends frames, queues replies.
  Assumes bitT is set to the device bit time in clocks.
*/
module smm_host (
  // Clock.
  input wire logic clk,
  // Serial lines.
  output logic txd,
  input wire logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  int bitT = 10;
  logic [8:0] q[$];

  initial txd = 1'b1;

  // Start low, data first bit first, stop high, then idle mark.
  task automatic bits(input logic [9:0] f);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      #1 txd = f[i];
      repeat (bitT - 1) @(posedge clk);
    end
    @(posedge clk);
    #1 txd = 1'b1;
  endtask

  task automatic send(input logic [7:0] b);
    bits({1'b1, b, 1'b0});
  endtask

  task automatic brk();
    bits(10'h000);
  endtask

  // A frame with a low stop bit is queued as a break.
  initial begin
    logic [8:0] v;
    forever begin
      @(negedge rxd);
      repeat (bitT / 2) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
        repeat (bitT) @(posedge clk);
        v[i] = rxd;
      end
      if (v[8])
        q.push_back({1'b0, v[7:0]});
      else begin
        q.push_back(9'h100);
        wait (rxd);
      end
    end
  end
endmodule

/* File: bench/tb_serial_monitor_mode.sv */
/*
  Self-checking bench for the serial monitor block.
  Assumes smm_host on the serial pins and a byte array as memory.
*/
module tb_serial_monitor_mode;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [31:0] tx;
    logic [2:0] nb;
    logic [15:0] ret;
    logic [1:0] nr;
  } smm_row_s;
  localparam smm_row_s rows [7] = '{
    '{32'h4901005a, 3'd4, 16'h0000, 2'd0},
    '{32'h4a010000, 3'd3, 16'h5a00, 2'd1},
    '{32'h19770000, 3'd2, 16'h0000, 2'd0},
    '{32'h1a000000, 3'd1, 16'hc33c, 2'd2},
    '{32'h4affff00, 3'd3, 16'h5e00, 2'd1},
    '{32'h1a000000, 3'd1, 16'ha1b2, 2'd2},
    '{32'h0c000000, 3'd1, 16'h4200, 2'd1}};
  logic clk = 1'b0, resetn = 1'b0, powerOnReset = 1'b1;
  logic externalInterruptPinLow = 1'b0, elevatedTestVoltage = 1'b0;
  logic resetVectorFetch = 1'b0, romExecAttempt = 1'b0;
  logic [15:0] resetVectorValue = 16'h0000;
  logic internalReset, illegalAddressReset, monitorMode, watchdogEnable;
  logic [15:0] resetVectorAddr, swiVectorAddr, memAddr;
  logic returnFromInterrupt, memRead, memWrite, memIsRom;
  logic [7:0] memWdata, memRdata;
  logic monitorReceivePin, monitorTransmitPin;
  logic [7:0] mem [0:65535];
  int failures = 0, comparisons = 0;

  always #2 clk = ~clk;
  assign memRdata = mem[memAddr];
  assign memIsRom = memAddr >= 16'he000;
  always @(posedge clk)
    if (memWrite) mem[memAddr] <= memWdata;

  smm_monitor #(.CLK_HZ(96000), .REF_DIV(8)) u_dut (
    .clk(clk), .resetn(resetn), .powerOnReset(powerOnReset),
    .externalInterruptPinLow(externalInterruptPinLow),
    .elevatedTestVoltage(elevatedTestVoltage),
    .resetVectorFetch(resetVectorFetch), .resetVectorValue(resetVectorValue),
    .romExecAttempt(romExecAttempt), .internalReset(internalReset),
    .illegalAddressReset(illegalAddressReset), .monitorMode(monitorMode),
    .watchdogEnable(watchdogEnable), .resetVectorAddr(resetVectorAddr),
    .swiVectorAddr(swiVectorAddr), .returnFromInterrupt(returnFromInterrupt),
    .stackPointer(8'h42), .memRead(memRead), .memWrite(memWrite),
    .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
    .memIsRom(memIsRom), .monitorReceivePin(monitorReceivePin),
    .monitorTransmitPin(monitorTransmitPin));

  smm_host u_host (.clk(clk), .txd(monitorReceivePin),
    .rxd(monitorTransmitPin));

  task automatic chk(input string n, input logic [15:0] e,
    input logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic chk1(input string n, input logic e, input logic s);
    chk(n, {15'h0000, e}, {15'h0000, s});
  endtask

  task automatic rx(input logic [8:0] e);
    int n;
    n = 0;
    while (u_host.q.size() == 0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    chk("rx", {7'h00, e}, n < 4000 ? {7'h00, u_host.q.pop_front()} : 16'hffff);
  endtask

  task automatic xfer(input logic [7:0] b);
    u_host.send(b);
    rx({1'b0, b});
    repeat (u_host.bitT) @(posedge clk);
  endtask

  task automatic cmd(input smm_row_s r);
    for (int i = 0; i < r.nb; i++)
      xfer(r.tx[31 - 8 * i -: 8]);
    for (int i = 0; i < r.nr; i++)
      rx({1'b0, r.ret[15 - 8 * i -: 8]});
  endtask

  // Power-on reset, erased vector fetch, then the security bytes.
  task automatic enter(input logic low, input logic [7:0] k);
    @(posedge clk);
    #1 resetn = 1'b0;
    powerOnReset = 1'b1;
    externalInterruptPinLow = low;
    u_host.q.delete();
    repeat (6) @(posedge clk);
    chk1("tx idle", 1'b1, monitorTransmitPin);
    chk("reset vector", 16'hfffe, resetVectorAddr);
    #1 resetn = 1'b1;
    @(posedge clk);
    #1 powerOnReset = 1'b0;
    resetVectorFetch = 1'b1;
    resetVectorValue = 16'h8000;
    @(posedge clk);
    #1 resetVectorValue = 16'hffff;
    chk1("no reset", 1'b0, internalReset);
    @(posedge clk);
    #1 resetVectorFetch = 1'b0;
    chk1("internal reset", 1'b1, internalReset);
    repeat (4) @(posedge clk);
    chk1("forced", 1'b1, monitorMode);
    chk1("watchdog", 1'b0, watchdogEnable);
    chk("swi vector", 16'hfefc, swiVectorAddr);
    u_host.bitT = low ? 16 : 10;
    for (int i = 0; i < 8; i++)
      xfer(mem[16'hfff6 + i] ^ k);
    rx(9'h100);
    repeat (20) @(posedge clk);
    chk1("flag", k == 8'h00, mem[16'h0060][6]);
  endtask

  task automatic end_sim();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    end_sim();
  end

  initial begin
    int n;
    for (int a = 0; a < 65536; a++)
      mem[a] = 8'h00;
    for (int i = 0; i < 8; i++)
      mem[16'hfff6 + i] = 8'h30 + 8'(i);
    mem[16'h0102] = 8'hc3;
    mem[16'h0103] = 8'h3c;
    mem[16'hffff] = 8'h5e;
    mem[16'h0000] = 8'ha1;
    mem[16'h0001] = 8'hb2;
    mem[16'hf000] = 8'h12;
    enter(1'b0, 8'h00);
    foreach (rows[i])
      cmd(rows[i]);
    chk("write", 16'h005a, {8'h00, mem[16'h0100]});
    chk("indexed_write_cmd", 16'h0077, {8'h00, mem[16'h0101]});
    // Break from the host comes back after a gap.
    u_host.brk();
    n = 0;
    while (monitorTransmitPin && n < 200) begin
      @(posedge clk);
      #1 n++;
    end
    chk1("break gap", 1'b1, n >= 10 && n <= 30);
    rx(9'h100);
    repeat (30) @(posedge clk);
    #1 romExecAttempt = 1'b1;
    #1 chk1("secured exec", 1'b0, illegalAddressReset);
    romExecAttempt = 1'b0;
    u_host.send(8'h28);
    rx(9'h028);
    n = 0;
    while (!returnFromInterrupt && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    chk1("run", 1'b1, returnFromInterrupt);
    // Reset other than power-on keeps mode and security.
    #1 resetn = 1'b0;
    repeat (6) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (3) @(posedge clk);
    chk1("forced again", 1'b1, monitorMode);
    repeat (300) @(posedge clk);
    u_host.q.delete();
    cmd(rows[6]);
    // Wrong code with the divided reference rate.
    enter(1'b1, 8'h01);
    cmd(smm_row_s'{32'h4af00000, 3'd3, 16'had00, 2'd1});
    #1 romExecAttempt = 1'b1;
    #1 chk1("illegal exec", 1'b1, illegalAddressReset);
    romExecAttempt = 1'b0;
    // High voltage entry and removal.
    @(posedge clk);
    #1 resetn = 1'b0;
    powerOnReset = 1'b1;
    elevatedTestVoltage = 1'b1;
    repeat (6) @(posedge clk);
    #1 resetn = 1'b1;
    @(posedge clk);
    #1 powerOnReset = 1'b0;
    #1 chk1("hv watchdog", 1'b0, watchdogEnable);
    elevatedTestVoltage = 1'b0;
    #1 chk1("watchdog back", 1'b1, watchdogEnable);
    end_sim();
  end
endmodule
